/* shared/lp_pkg.sv */
// Purpose: constants and types shared by the low-power mode controller
// Assumes: single clock domain, core oscillator clock
// Notes: stabilisation length is a top-level parameter as well
package lp_pkg;
    // default oscillator stabilisation delay in oscillator cycles
    localparam int unsigned STAB_CYCLES_DEF = 256;
    // reset value of the global interrupt enable
    localparam logic GIE_RESET = 1'b0;
    // core context when the low-power instruction was taken
    typedef enum logic [1:0] {
        CTX_MAIN,
        CTX_IRQ,
        CTX_NMI
    } ctx_t;
    // controller states
    typedef enum logic [1:0] {
        ST_RUN,
        ST_WAIT,
        ST_STOP,
        ST_STAB
    } lp_state_t;
    // resume action reported to the core on wake-up
    typedef enum logic [1:0] {
        RES_NONE,
        RES_SERVICE_IRQ,
        RES_SERVICE_NMI,
        RES_CONTINUE
    } resume_t;
endpackage : lp_pkg

/* rtl/stab_counter.sv */
// Purpose: oscillator stabilisation down-counter
// Assumes: start is a one-cycle pulse, count given in oscillator cycles
// Notes: done pulses once when the count has elapsed
`timescale 1ns/10ps
module stab_counter #(
    parameter int unsigned CYCLES = 256
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // control
    input wire logic start,
    output logic done
);
    localparam int unsigned W = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic busy;
        logic done;
    } cnt_state_t;

    cnt_state_t s_q, s_d;

    initial begin
        if (CYCLES < 1) $error("stab_counter: CYCLES must be at least 1");
    end

    // load on start, count down, flag the last cycle
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (start) begin
            s_d.cnt = W'(CYCLES);
            s_d.busy = 1'b1;
        end else if (s_q.busy) begin
            if (s_q.cnt == W'(1)) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
            s_d.cnt = s_q.cnt - W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
endmodule : stab_counter

/* rtl/wait_stop_power_control.sv */
// Purpose: wait/stop low-power mode controller beside a small 8-bit core
// Assumes: resetn is the combined pin and watchdog reset; inputs synchronous to ref_clk
// Notes: the oscillator gate is an enable for the clock generator, not a gated clock
// Notes: resume_action tells the core how to restart; it stands from the wake pulse
// Notes: until the first cycle back in run, so the core must take it with the pulse
// Notes: watchdog options are levels; a stop taken while either is set runs as wait
// Notes: with the global enable low only resetn brings the core back
// How it works
// - wait halts instruction fetch at once; ram, registers and peripherals keep going
// - in wait the oscillator keeps running so peripheral interrupts can wake
// - a pin or watchdog reset ending wait performs the normal reset
// - waking from wait by interrupt resumes with no stabilisation delay
// - stop only with watchdog off; otherwise a stop instruction acts as wait
// - stop halts oscillator and fetch; only external interrupt, nmi or reset leaves it
// - pin reset ending stop performs the normal reset
// - waking from stop by interrupt inserts a stabilisation delay before fetch
// - from main routine any interrupt wakes, is serviced, then execution continues
// - from nmi routine any interrupt wakes; continue next instruction, stay nmi
// - from irq routine, normal irq wakes; continue routine in irq mode
// - from irq routine, nmi wakes; nmi serviced first, then routine continues
// - global enable low: only reset restarts; nmi serviceable but cannot wake
// - wait or stop is ignored when an enabled interrupt is already pending
// - interrupt wake-up leaves oscillator selection unchanged
// - global enable set allows all interrupts; clear allows only nmi; reset clears
`timescale 1ns/10ps
module wait_stop_power_control
    import lp_pkg::*;
#(
    parameter int unsigned STAB_CYCLES = STAB_CYCLES_DEF
) (
    // clock, reset and enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // core instruction decode, one-cycle pulses
    input wire logic wait_instr,
    input wire logic stop_instr,
    input wire logic [1:0] core_ctx,
    // global interrupt enable write from the core
    input wire logic gie_wr,
    input wire logic gie_wdata,
    // watchdog options
    input wire logic wdog_hw_sel,
    input wire logic wdog_sw_en,
    // interrupt requests: enabled peripheral, external pin, nmi
    input wire logic periph_irq,
    input wire logic ext_irq,
    input wire logic nmi_req,
    // oscillator selection requested by the core
    input wire logic osc_sel_in,
    // to the core and clock generator
    output logic global_irq_enable,
    output logic core_halt,
    output logic osc_run,
    output logic osc_sel,
    output logic wake_pulse,
    output logic [1:0] resume_action,
    output logic instr_ignored,
    output logic [1:0] lp_state
);
    typedef struct packed {
        lp_state_t st;
        logic gie;
        logic osc_sel;
        ctx_t ctx;
        resume_t pend_res;
        resume_t res;
        logic wake;
        logic ign;
    } top_state_t;

    top_state_t s_q, s_d;
    logic stab_start;
    logic stab_done;
    logic stop_ok;
    logic wake_any;
    logic pending_en;
    resume_t act;

    // named wake and entry conditions
    logic maskable_irq;
    logic wait_wake;
    logic stop_wake;
    logic lp_req;
    logic go_stop;
    logic gie_next;

    // refuse parameters and codes the logic cannot serve
    initial begin
        if (STAB_CYCLES < 1) $error("wait_stop_power_control: STAB_CYCLES must be at least 1");
        if ($bits(lp_state_t) != 2) $error("wait_stop_power_control: state code must fit lp_state");
        if ($bits(resume_t) != 2) $error("wait_stop_power_control: resume code must fit resume_action");
        if ($bits(ctx_t) != 2) $error("wait_stop_power_control: context code must fit core_ctx");
    end

    // stabilisation timer in oscillator cycles
    stab_counter #(
        .CYCLES(STAB_CYCLES)
    ) u_stab (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .start(stab_start),
        .done(stab_done)
    );

    // qualifiers
    always_comb begin
        // maskable sources only count with the global enable set
        maskable_irq = s_q.gie && (periph_irq || ext_irq);
        stop_ok = !(wdog_hw_sel || wdog_sw_en);
        pending_en = maskable_irq || nmi_req;
        // nmi never wakes with the enable low; maskables need it too
        wake_any = s_q.gie && (periph_irq || ext_irq || nmi_req);
        wait_wake = wake_any;
        // a stopped oscillator leaves only pin-driven requests able to wake
        stop_wake = s_q.gie && (ext_irq || nmi_req);
        lp_req = wait_instr || stop_instr;
        go_stop = stop_instr && stop_ok;
        act = RES_CONTINUE;
        case (s_q.ctx)
            CTX_MAIN: act = nmi_req ? RES_SERVICE_NMI : RES_SERVICE_IRQ;
            CTX_NMI: act = RES_CONTINUE;
            CTX_IRQ: act = nmi_req ? RES_SERVICE_NMI : RES_CONTINUE;
            default: act = RES_CONTINUE;
        endcase
    end

    // global enable write; wake decisions in this cycle still use the old value
    always_comb begin
        gie_next = s_q.gie;
        if (gie_wr) begin
            gie_next = gie_wdata;
        end
    end

    // mode sequencing
    always_comb begin
        s_d = s_q;
        s_d.wake = 1'b0;
        s_d.ign = 1'b0;
        stab_start = 1'b0;
        s_d.gie = gie_next;
        case (s_q.st)
            // running: track selection, take or drop low-power instructions
            ST_RUN: begin
                // selection follows the core only here, so a wake keeps it
                s_d.osc_sel = osc_sel_in;
                s_d.res = RES_NONE;
                if (lp_req) begin
                    if (pending_en) begin
                        s_d.ign = 1'b1;
                    end else begin
                        s_d.ctx = ctx_t'(core_ctx);
                        // a stop with the watchdog on becomes a wait
                        s_d.st = go_stop ? ST_STOP : ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                // oscillator still runs, wake straight back to run
                if (wait_wake) begin
                    s_d.st = ST_RUN;
                    s_d.res = act;
                    s_d.wake = 1'b1;
                end
            end
            ST_STOP: begin
                // only external or nmi requests can reach a stopped core
                if (stop_wake) begin
                    s_d.st = ST_STAB;
                    s_d.pend_res = act;
                    stab_start = 1'b1;
                end
            end
            // oscillator settling; fetch stays halted until the timer ends
            ST_STAB: begin
                if (stab_done) begin
                    s_d.st = ST_RUN;
                    s_d.res = s_q.pend_res;
                    s_d.wake = 1'b1;
                end
            end
            // a value outside the four state codes falls back to run
            default: s_d.st = ST_RUN;
        endcase
    end

    // reset returns everything to run: the normal reset procedure
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_q.st <= ST_RUN;
            s_q.gie <= GIE_RESET;
            s_q.osc_sel <= 1'b0;
            s_q.ctx <= CTX_MAIN;
            s_q.pend_res <= RES_NONE;
            s_q.res <= RES_NONE;
            s_q.wake <= 1'b0;
            s_q.ign <= 1'b0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // enable as seen by the core
    assign global_irq_enable = s_q.gie;

    // halt and oscillator gating
    assign core_halt = (s_q.st != ST_RUN);
    assign osc_run = (s_q.st != ST_STOP);

    // outputs; selection frozen outside run so wake keeps it
    assign osc_sel = s_q.osc_sel;
    assign wake_pulse = s_q.wake;
    assign resume_action = s_q.res;
    assign instr_ignored = s_q.ign;
    assign lp_state = s_q.st;
endmodule : wait_stop_power_control

/* verif/irq_source.sv */
// Purpose: interrupt request lines seen by the controller from the core side
// Assumes: fire is raised for one cycle or more; sel 0 periph, 1 external, 2 nmi
// Notes: a request stands until the wake pulse services it or reset clears it
`timescale 1ns/10ps
module irq_source (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // control
    input wire logic fire,
    input wire logic [1:0] sel,
    input wire logic wake_pulse,
    // requests
    output logic [2:0] irq_q
);
    // request latches, cleared when serviced
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_q <= 3'h0;
        end else if (wake_pulse) begin
            irq_q <= 3'h0;
        end else if (fire) begin
            irq_q[sel] <= 1'b1;
        end
    end
endmodule : irq_source

/* verif/lp_checker.sv */
// Purpose: port checks for the low-power controller
// Assumes: one clock domain, resetn active low
// Notes: cnt_q counts stabilisation cycles
`timescale 1ns/10ps
module lp_checker #(parameter int unsigned STAB_CYCLES = 256) (
    // clock and reset
    input wire logic ref_clk, resetn, clk_en,
    // requests
    input wire logic wait_instr, stop_instr, wdog_hw_sel, wdog_sw_en, periph_irq, ext_irq, nmi_req,
    // responses
    input wire logic global_irq_enable, osc_run, osc_sel, wake_pulse, instr_ignored,
    input wire logic [1:0] lp_state
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    wire logic pend = nmi_req || (global_irq_enable && (periph_irq || ext_irq));
    // count cycles spent stabilising
    assign cnt_d = (lp_state == 2'h3) ? cnt_q + 16'(clk_en) : 16'h0;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 16'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    // instruction taken in run with nothing pending
    sequence s_taken;
        clk_en && lp_state == 2'h0 && !pend;
    endsequence
    a_wait_entry: assert property (s_taken ##0 wait_instr |=> lp_state == 2'h1 && osc_run)
        else $error("wait not entered");
    a_stop_as_wait: assert property (s_taken ##0 (stop_instr && (wdog_hw_sel || wdog_sw_en)) |=> lp_state == 2'h1)
        else $error("stop not turned into wait");
    a_stop_entry: assert property (s_taken ##0 (stop_instr && !wdog_hw_sel && !wdog_sw_en) |=> !osc_run)
        else $error("stop left oscillator running");
    a_wait_wake: assert property (
        lp_state == 2'h1 && clk_en && global_irq_enable && (periph_irq || ext_irq || nmi_req)
        |=> wake_pulse && lp_state == 2'h0)
        else $error("wait wake late");
    a_stop_stab: assert property (lp_state == 2'h2 && clk_en && global_irq_enable && ext_irq
        |=> lp_state == 2'h3 && osc_run ##1 !wake_pulse)
        else $error("stop wake without stabilisation");
    a_stab_count: assert property (lp_state == 2'h0 && $past(lp_state) == 2'h3 |-> cnt_q == 16'(STAB_CYCLES + 1))
        else $error("stabilisation length wrong");
    a_gie_blocks: assert property (!global_irq_enable && lp_state inside {2'h1, 2'h2} |=> !wake_pulse)
        else $error("woke with global enable low");
    a_pending_drop: assert property (clk_en && lp_state == 2'h0 && pend && (wait_instr || stop_instr)
        |=> instr_ignored && lp_state == 2'h0)
        else $error("instruction not dropped");
    a_osc_frozen: assert property (lp_state != 2'h0 && $past(lp_state) != 2'h0 |-> $stable(osc_sel))
        else $error("oscillator selection changed");
endmodule : lp_checker
bind wait_stop_power_control lp_checker #(.STAB_CYCLES(STAB_CYCLES)) u_lp_checker (.ref_clk(ref_clk),
    .resetn(resetn), .clk_en(clk_en), .wait_instr(wait_instr), .stop_instr(stop_instr), .wdog_hw_sel(wdog_hw_sel),
    .wdog_sw_en(wdog_sw_en), .periph_irq(periph_irq), .ext_irq(ext_irq), .nmi_req(nmi_req), .osc_sel(osc_sel),
    .global_irq_enable(global_irq_enable), .osc_run(osc_run), .wake_pulse(wake_pulse),
    .instr_ignored(instr_ignored), .lp_state(lp_state));

/* verif/tb_wait_stop_power_control.sv */
// Purpose: self-checking bench for the low-power controller
// Assumes: stabilisation shortened to 4 cycles
// Notes: inputs change on the falling edge
`timescale 1ns/10ps
module tb_wait_stop_power_control;
    import lp_pkg::*;
    localparam int STAB = 4;
    typedef struct {logic stp; logic [1:0] wd; logic [1:0] ctx; logic [1:0] src; logic [1:0] st; resume_t res;} row_t;
    // stop, watchdog, context, wake source, state entered, resume action
    row_t rows [8] = '{'{0, 0, 0, 0, 1, RES_SERVICE_IRQ}, '{0, 0, 0, 2, 1, RES_SERVICE_NMI},
        '{0, 0, 2, 1, 1, RES_CONTINUE}, '{0, 0, 1, 0, 1, RES_CONTINUE}, '{1, 0, 1, 2, 2, RES_SERVICE_NMI},
        '{1, 0, 0, 1, 2, RES_SERVICE_IRQ}, '{1, 2, 0, 0, 1, RES_SERVICE_IRQ}, '{1, 1, 2, 1, 1, RES_CONTINUE}};
    logic ref_clk = 0, resetn = 0, wi = 0, si = 0, gw = 0, gd = 0, hw = 0, sw = 0, osi = 0, fire = 0;
    logic [1:0] ctx = 0, sel = 0, act, st;
    logic [2:0] irq;
    logic gie, halt, orun, osel, wake, ign;
    int errors = 0, compares = 0, cyc = 0, n;
    initial forever #2 ref_clk = ~ref_clk;
    wait_stop_power_control #(.STAB_CYCLES(STAB)) DUT (.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
        .wait_instr(wi), .stop_instr(si), .core_ctx(ctx), .gie_wr(gw), .gie_wdata(gd), .wdog_hw_sel(hw),
        .wdog_sw_en(sw), .periph_irq(irq[0]), .ext_irq(irq[1]), .nmi_req(irq[2]), .osc_sel_in(osi),
        .global_irq_enable(gie), .core_halt(halt), .osc_run(orun), .osc_sel(osel), .wake_pulse(wake),
        .resume_action(act), .instr_ignored(ign), .lp_state(st));
    irq_source PEER (.ref_clk(ref_clk), .resetn(resetn), .fire(fire), .sel(sel), .wake_pulse(wake), .irq_q(irq));
    // cut a hang short
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic stop_test();
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    // one instruction pulse from the given context
    task automatic instr(input logic stp, input logic [1:0] c);
        @(negedge ref_clk);
        si = stp;
        wi = !stp;
        ctx = c;
        @(negedge ref_clk);
        si = 0;
        wi = 0;
    endtask : instr
    // table cases, then dropped instruction, blocked wake and reset exits
    initial begin
        repeat (8) @(negedge ref_clk);
        resetn = 1;
        gw = 1;
        gd = 1;
        @(negedge ref_clk);
        gw = 0;
        chk("gie", gie, 1);
        foreach (rows[i]) begin
            {hw, sw} = rows[i].wd;
            instr(rows[i].stp, rows[i].ctx);
            chk("state", st, rows[i].st);
            chk("osc_run", orun, rows[i].st != 2);
            osi = 1;
            sel = rows[i].src;
            fire = 1;
            n = 0;
            while (wake !== 1'b1 && n < 20) begin
                @(negedge ref_clk);
                fire = 0;
                n++;
            end
            chk("latency", 8'(n), rows[i].st == 2 ? 8'(STAB + 3) : 8'h02);
            chk("resume", act, rows[i].res);
            chk("osc_sel", osel, 0);
            osi = 0;
            @(negedge ref_clk);
            chk("resume clear", act, RES_NONE);
        end
        {hw, sw} = 2'h0;
        sel = 2;
        fire = 1;
        @(negedge ref_clk);
        fire = 0;
        instr(0, 0);
        chk("ignored", {ign, st}, 8'h04);
        for (int k = 0; k < 3; k++) begin
            resetn = 0;
            @(negedge ref_clk);
            chk("reset", {gie, halt, orun, wake, act, st}, 8'h20);
            if (k == 2) begin
                stop_test();
            end
            resetn = 1;
            instr(k[0], 0);
            sel = k[0] ? 2'h2 : 2'h1;
            fire = 1;
            repeat (6) @(negedge ref_clk);
            fire = 0;
            chk("no wake", st, 8'(k + 1));
        end
    end
endmodule : tb_wait_stop_power_control
